/* logic/buf_irq_pkg.sv */
// Constants for the buffer and interrupt register bank
// What this block does
// - Control bit 7 picks capacity: 1 gives 255 bytes, 0 gives 512 bytes.
// - Near-full bit 6 reads 1 when capacity minus count is at most the warning level.
// - Near-empty bit 5 reads 1 when count is at most the warning level.
// - Writing 1 to bit 4 empties the buffer; the bit always reads 0.
// - Control bit 2 is warning level bit 8, used only in 512-byte mode.
// - Control bits 1..0 show count bits 9..8, meaningful only in 512-byte mode.
// - Count resets to zero, rises per port write, falls per port read.
// - Data port accesses leave the interface address pointer unchanged.
// - Request writes: bit 7 picks set or clear, ones select flags.
// - In request register b only bits 5..0 are host writable.
// - Near-full and near-empty requests latch on the alert and stay set.
// - Command-done request sets on self-ending commands, not on host idle.
// - Transmit-done request sets when the last bit has been sent.
// - Receive-done request sets at end of stream, correct or not.
// - Frame-start request sets on a start symbol or subcarrier.
// - Error request sets when any of five error flags becomes set.
// - Timer requests bits 4..0 set on the matching timer underflow.
// - Card-detect request bit 5 sets when low-power detection finds a card.
// - Any-enabled request sets when an enabled flag is set.
// - Pin follows any-enabled request only when enabled; enable a bit 7 inverts.
// - Enable b bit 7 picks push-pull when 1, open-drain when 0.
// - Writes to a full buffer are dropped and flag an overflow error.
package buf_irq_pkg;
   localparam logic [7:0]  OFS_CONTROL   = 8'h02;
   localparam logic [7:0]  OFS_WARNING   = 8'h03;
   localparam logic [7:0]  OFS_COUNT     = 8'h04;
   localparam logic [7:0]  OFS_PORT      = 8'h05;
   localparam logic [7:0]  OFS_REQ_A     = 8'h06;
   localparam logic [7:0]  OFS_REQ_B     = 8'h07;
   localparam logic [7:0]  OFS_EN_A      = 8'h08;
   localparam logic [7:0]  OFS_EN_B      = 8'h09;
   localparam int          BIT_CAPACITY  = 7;
   localparam int          BIT_NEAR_FULL = 6;
   localparam int          BIT_NEAR_EMP  = 5;
   localparam int          BIT_CLEAR     = 4;
   localparam int          BIT_WL_MSB    = 2;
   localparam int          BIT_SET       = 7;
   localparam int          BIT_ANY       = 6;
   localparam int          BIT_PIN_EN    = 6;
   localparam int          BIT_DRIVE     = 7;
   localparam int          BIT_INVERT    = 7;
   localparam logic [9:0]  CAP_SMALL     = 10'h0ff;
   localparam logic [9:0]  CAP_LARGE     = 10'h200;
   localparam int          DEPTH         = 512;
   localparam logic [7:0]  RST_CONTROL   = 8'h00;
   localparam logic [7:0]  RST_WARNING   = 8'h00;
   localparam logic [7:0]  RST_REQ       = 8'h00;
   localparam logic [7:0]  RST_EN        = 8'h00;
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;
endpackage : buf_irq_pkg

/* logic/buf_irq_regs.sv */
// Buffer and interrupt register bank behind an AXI4-Lite slave
module buf_irq_regs
   import buf_irq_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        cmd_self_end,
   input  wire logic        tx_last_bit,
   input  wire logic        rx_end,
   input  wire logic        rx_frame_start,
   input  wire logic [4:0]  error_flags,
   input  wire logic [4:0]  timer_underflow,
   input  wire logic        card_detect,
   output logic             overflow_error,
   output logic             irq_out,
   output logic             irq_oe
);

   // ********************
   // Bus handshake
   // ********************
   logic [7:0]  aw_idx;
   logic [7:0]  wbyte;
   logic        aw_held;
   logic        w_held;
   logic        wr_fire;
   logic [7:0]  ar_idx;
   logic        rd_fire;
   logic        aw_ok;
   logic        ar_ok;

   assign aw_ok   = s_axi_awaddr[1:0] == 2'b00 && s_axi_awaddr[31:10] == 22'h0;
   assign ar_ok   = s_axi_araddr[1:0] == 2'b00 && s_axi_araddr[31:10] == 22'h0;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   logic aw_bad;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_held       <= 1'b0;
         aw_idx        <= 8'h00;
         aw_bad        <= 1'b0;
      end else if (wr_fire) begin
         aw_held       <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_held       <= 1'b1;
         aw_idx        <= s_axi_awaddr[9:2];
         aw_bad        <= !aw_ok;
      end else if (!aw_held && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   logic w_lane;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_held       <= 1'b0;
         wbyte        <= 8'h00;
         w_lane       <= 1'b0;
      end else if (wr_fire) begin
         w_held       <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_held       <= 1'b1;
         wbyte        <= s_axi_wdata[7:0];
         w_lane       <= s_axi_wstrb[0];
      end else if (!w_held && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   logic hit;
   assign hit = !aw_bad && aw_idx >= OFS_CONTROL && aw_idx <= OFS_EN_B;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Byte lane 0 carries the register; other lanes are ignored
   logic wr_do;
   assign wr_do = wr_fire && hit && w_lane;

   // ********************
   // Registers
   // ********************
   logic        cap_small;
   logic        wl_msb;
   logic [7:0]  warning;
   logic [7:0]  en_a;
   logic [7:0]  en_b;
   logic [9:0]  count;
   logic [9:0]  capacity;
   logic [8:0]  level;
   logic        near_full;
   logic        near_empty;
   logic        port_wr;
   logic        port_rd;
   logic        clear_buf;
   logic        full;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_small <= RST_CONTROL[BIT_CAPACITY];
         wl_msb    <= RST_CONTROL[BIT_WL_MSB];
      end else if (wr_do && aw_idx == OFS_CONTROL) begin
         cap_small <= wbyte[BIT_CAPACITY];
         wl_msb    <= wbyte[BIT_WL_MSB];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         warning <= RST_WARNING;
         en_a    <= RST_EN;
         en_b    <= RST_EN;
      end else if (wr_do) begin
         if (aw_idx == OFS_WARNING) warning <= wbyte;
         if (aw_idx == OFS_EN_A) en_a <= wbyte;
         if (aw_idx == OFS_EN_B) en_b <= wbyte;
      end
   end

   assign capacity   = cap_small ? CAP_SMALL : CAP_LARGE;
   assign level      = {cap_small ? 1'b0 : wl_msb, warning};
   assign near_full  = (capacity - count) <= {1'b0, level};
   assign near_empty = count <= {1'b0, level};
   assign full       = count >= capacity;
   assign clear_buf  = wr_do && aw_idx == OFS_CONTROL && wbyte[BIT_CLEAR];
   assign port_wr    = wr_do && aw_idx == OFS_PORT;
   assign port_rd    = rd_fire && ar_ok && s_axi_araddr[9:2] == OFS_PORT && count != 10'h0;

   // ********************
   // Storage, pointers carry no address increment on the data port
   // ********************
   logic [7:0] mem [DEPTH];
   logic [8:0] wr_ptr;
   logic [8:0] rd_ptr;

   always_ff @(posedge aclk) begin
      if (port_wr && !full) mem[wr_ptr] <= wbyte;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || clear_buf) begin
         wr_ptr <= 9'h000;
         rd_ptr <= 9'h000;
         count  <= 10'h000;
      end else begin
         if (port_wr && !full) wr_ptr <= wr_ptr + 9'h001;
         if (port_rd) rd_ptr <= rd_ptr + 9'h001;
         case ({port_wr && !full, port_rd})
            2'b10:   count <= count + 10'h001;
            2'b01:   count <= count - 10'h001;
            default: count <= count;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || clear_buf) overflow_error <= 1'b0;
      else if (port_wr && full) overflow_error <= 1'b1;
   end

   // ********************
   // Request flags: hardware set wins over host clear
   // ********************
   logic [6:0] req_a;
   logic [5:0] req_b;
   logic [6:0] hw_a;
   logic [5:0] hw_b;
   logic [4:0] err_q;
   logic       nf_q;
   logic       ne_q;
   logic       any_req;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_q <= 5'h00;
         nf_q  <= 1'b0;
         ne_q  <= 1'b0;
      end else begin
         err_q <= error_flags;
         nf_q  <= near_full;
         ne_q  <= near_empty;
      end
   end

   assign hw_a = {near_full && !nf_q,
                  near_empty && !ne_q,
                  cmd_self_end,
                  tx_last_bit,
                  rx_end,
                  |(error_flags & ~err_q),
                  rx_frame_start};
   assign hw_b = {card_detect, timer_underflow};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_a <= RST_REQ[6:0];
      end else begin
         if (wr_do && aw_idx == OFS_REQ_A)
            req_a <= (wbyte[BIT_SET] ? (req_a | wbyte[6:0]) : (req_a & ~wbyte[6:0])) | hw_a;
         else
            req_a <= req_a | hw_a;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_b <= RST_REQ[5:0];
      end else begin
         if (wr_do && aw_idx == OFS_REQ_B)
            req_b <= (wbyte[BIT_SET] ? (req_b | wbyte[5:0]) : (req_b & ~wbyte[5:0])) | hw_b;
         else
            req_b <= req_b | hw_b;
      end
   end

   assign any_req = |(req_a & en_a[6:0]) || |(req_b & en_b[5:0]);

   // ********************
   // Interrupt pin
   // ********************
   logic pin_level;
   assign pin_level = (en_b[BIT_PIN_EN] && any_req) ^ en_a[BIT_INVERT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_out <= 1'b0;
         irq_oe  <= 1'b0;
      end else begin
         irq_out <= pin_level;
         irq_oe  <= en_b[BIT_DRIVE] ? 1'b1 : !pin_level;
      end
   end

   // ********************
   // Read path
   // ********************
   logic [7:0] rbyte;
   always_comb begin
      rbyte = 8'h00;
      case (s_axi_araddr[9:2])
         OFS_CONTROL: rbyte = {cap_small, near_full, near_empty, 1'b0, 1'b0,
                               wl_msb, count[9:8]};
         OFS_WARNING: rbyte = warning;
         OFS_COUNT:   rbyte = count[7:0];
         OFS_PORT:    rbyte = mem[rd_ptr];
         OFS_REQ_A:   rbyte = {1'b0, req_a};
         OFS_REQ_B:   rbyte = {1'b0, any_req, req_b};
         OFS_EN_A:    rbyte = en_a;
         OFS_EN_B:    rbyte = en_b;
         default:     rbyte = 8'h00;
      endcase
   end

   logic rd_hit;
   assign rd_hit = ar_ok && s_axi_araddr[9:2] >= OFS_CONTROL && s_axi_araddr[9:2] <= OFS_EN_B;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h00_0000, rd_hit ? rbyte : 8'h00};
         s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ********************
   // Checks
   // ********************
   property p_count_up;
      @(posedge aclk) disable iff (!aresetn)
      (port_wr && !full && !port_rd && !clear_buf) |=> count == $past(count) + 10'h001;
   endproperty
   a_count_up: assert property (p_count_up) else $error("count did not rise");

   property p_full_drop;
      @(posedge aclk) disable iff (!aresetn)
      (port_wr && full && !port_rd && !clear_buf) |=> overflow_error && count == $past(count);
   endproperty
   a_full_drop: assert property (p_full_drop) else $error("full write not dropped");

   property p_clear;
      @(posedge aclk) disable iff (!aresetn)
      clear_buf |=> count == 10'h000;
   endproperty
   a_clear: assert property (p_clear) else $error("buffer not cleared");

   property p_latch_nf;
      @(posedge aclk) disable iff (!aresetn)
      (near_full && !nf_q) |=> req_a[6];
   endproperty
   a_latch_nf: assert property (p_latch_nf) else $error("near full not latched");

   property p_timer;
      @(posedge aclk) disable iff (!aresetn)
      timer_underflow[0] |=> req_b[0];
   endproperty
   a_timer: assert property (p_timer) else $error("timer request lost");

   property p_err;
      @(posedge aclk) disable iff (!aresetn)
      |(error_flags & ~err_q) |=> req_a[1];
   endproperty
   a_err: assert property (p_err) else $error("error request lost");

   property p_pin;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> irq_out == (($past(en_b[BIT_PIN_EN]) && $past(any_req)) ^ $past(en_a[BIT_INVERT]));
   endproperty
   a_pin: assert property (p_pin) else $error("pin level wrong");

   property p_drive;
      @(posedge aclk) disable iff (!aresetn)
      $past(en_b[BIT_DRIVE]) |-> irq_oe;
   endproperty
   a_drive: assert property (p_drive) else $error("push-pull not driving");

   property p_near_empty;
      @(posedge aclk) disable iff (!aresetn)
      (count == 10'h000) |-> near_empty;
   endproperty
   a_near_empty: assert property (p_near_empty) else $error("near empty wrong");

   property p_drive_mode;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> irq_oe == ($past(en_b[BIT_DRIVE]) || !irq_out);
   endproperty
   a_drive_mode: assert property (p_drive_mode) else $error("open-drain pin drives high");

   // Port read that is not cancelled by a write or a clear, then one byte less
   sequence s_port_pop;
      port_rd && !(port_wr && !full) && !clear_buf;
   endsequence

   sequence s_count_fell;
      count == $past(count) - 10'h001;
   endsequence

   property p_count_down;
      @(posedge aclk) disable iff (!aresetn)
      s_port_pop |=> s_count_fell;
   endproperty
   a_count_down: assert property (p_count_down) else $error("count did not fall");

endmodule : buf_irq_regs

/* tb/axi_host.sv */
// AXI4-Lite host model that reaches the register bank
module axi_host (
   input  wire logic        aclk,
   output logic [31:0]      awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [31:0]      araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {awaddr, wdata, araddr} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'h0;
   end

   // Released address and data lines are scrambled so stale values cannot pass for live ones; wstrb is left at 4'hf
   task automatic wr(input logic [7:0] ofs, input logic [7:0] dat, output logic [1:0] resp);
      @(posedge aclk);
      awaddr  <= 32'({ofs, 2'b00});
      awvalid <= 1'b1;
      wdata   <= 32'(dat);
      wstrb   <= 4'hf;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (awready !== 1'b1);
            awvalid <= 1'b0;
            awaddr  <= ~awaddr;
         end
         begin
            do @(posedge aclk); while (wready !== 1'b1);
            wvalid <= 1'b0;
            wdata  <= ~wdata;
         end
      join
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] ofs, output logic [31:0] dat, output logic [1:0] resp);
      @(posedge aclk);
      araddr  <= 32'({ofs, 2'b00});
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      araddr  <= ~araddr;
      do @(posedge aclk); while (rvalid !== 1'b1);
      dat  = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : axi_host

/* tb/tb.sv */
// Self-checking bench for the buffer and interrupt register bank
module tb
   import buf_irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        aclk = 1'b0;
   logic        aresetn;
   logic [31:0] awaddr, wdata, araddr, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, ovf, irq_out, irq_oe;
   logic [14:0] src;
   int          error_cnt = 0;
   int          n_tests = 0;

   always #2 aclk = ~aclk;

   buf_irq_regs buf_irq_regs_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cmd_self_end(src[8]), .tx_last_bit(src[7]), .rx_end(src[6]),
      .rx_frame_start(src[0]), .error_flags(src[5:1]), .timer_underflow(src[13:9]),
      .card_detect(src[14]), .overflow_error(ovf), .irq_out(irq_out), .irq_oe(irq_oe));

   axi_host axi_host_inst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_n(input int n);
      repeat (n) @(posedge aclk);
   endtask : wait_n

   task automatic wr(input logic [7:0] o, input logic [7:0] v);
      axi_host_inst.wr(o, v, r);
      chk(32'(r), 32'(RESP_OKAY));
   endtask : wr

   task automatic rd_chk(input logic [7:0] o, input logic [7:0] e);
      axi_host_inst.rd(o, d, r);
      chk(32'(r), 32'(RESP_OKAY));
      chk(d, 32'(e));
   endtask : rd_chk

   task automatic pin(input logic [1:0] e);
      wait_n(3);
      chk(32'({irq_oe, irq_out}), 32'(e));
   endtask : pin

   task automatic wrap_up();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      rd_chk(OFS_CONTROL, 8'h20);
      rd_chk(OFS_COUNT, 8'h00);
      rd_chk(OFS_REQ_A, 8'h20);
      rd_chk(OFS_REQ_B, 8'h00);
      axi_host_inst.rd(8'h0a, d, r);
      chk(d, 32'h0000_0000);
      chk(32'(r), 32'(RESP_SLVERR));
      axi_host_inst.wr(8'h0a, 8'h55, r);
      chk(32'(r), 32'(RESP_SLVERR));
   endtask : t_reset

   task automatic t_data();
      wr(OFS_WARNING, 8'h02);
      for (int i = 0; i < 3; i++) wr(OFS_PORT, 8'ha1 + 8'(i));
      rd_chk(OFS_COUNT, 8'h03);
      rd_chk(OFS_CONTROL, 8'h00);
      for (int i = 0; i < 3; i++) rd_chk(OFS_PORT, 8'ha1 + 8'(i));
      rd_chk(OFS_COUNT, 8'h00);
      for (int i = 0; i < 260; i++) wr(OFS_PORT, 8'(i));
      rd_chk(OFS_COUNT, 8'h04);
      wr(OFS_CONTROL, 8'h04);
      rd_chk(OFS_CONTROL, 8'h45);
      wr(OFS_CONTROL, 8'h14);
      rd_chk(OFS_COUNT, 8'h00);
      rd_chk(OFS_CONTROL, 8'h24);
   endtask : t_data

   task automatic t_small();
      wr(OFS_WARNING, 8'h00);
      wr(OFS_CONTROL, 8'h84);
      rd_chk(OFS_CONTROL, 8'ha4);
      wr(OFS_REQ_A, 8'h7f);
      for (int i = 0; i < 255; i++) wr(OFS_PORT, 8'(i));
      rd_chk(OFS_COUNT, 8'hff);
      rd_chk(OFS_CONTROL, 8'hc4);
      chk(32'(ovf), 32'h0000_0000);
      wr(OFS_PORT, 8'h5a);
      wait_n(2);
      chk(32'(ovf), 32'h0000_0001);
      rd_chk(OFS_COUNT, 8'hff);
      rd_chk(OFS_PORT, 8'h00);
      wr(OFS_CONTROL, 8'h90);
      wait_n(2);
      chk(32'(ovf), 32'h0000_0000);
      axi_host_inst.rd(OFS_REQ_A, d, r);
      chk(d & 32'h0000_0060, 32'h0000_0060);
      wr(OFS_CONTROL, 8'h00);
   endtask : t_small

   task automatic t_setclr();
      wr(OFS_REQ_A, 8'h7f);
      rd_chk(OFS_REQ_A, 8'h00);
      wr(OFS_REQ_A, 8'h85);
      rd_chk(OFS_REQ_A, 8'h05);
      wr(OFS_REQ_A, 8'h04);
      rd_chk(OFS_REQ_A, 8'h01);
      wr(OFS_REQ_A, 8'hff);
      rd_chk(OFS_REQ_A, 8'h7f);
      wr(OFS_REQ_B, 8'hff);
      rd_chk(OFS_REQ_B, 8'h3f);
      wr(OFS_REQ_B, 8'h7f);
      rd_chk(OFS_REQ_B, 8'h00);
      wr(OFS_REQ_A, 8'h7f);
   endtask : t_setclr

   task automatic t_events();
      logic [7:0] ea, eb;
      for (int i = 0; i < 15; i++) begin
         ea = (i == 0) ? 8'h01 : (i < 6) ? 8'h02 : (i < 9) ? 8'(8'h04 << (i - 6)) : 8'h00;
         eb = (i > 8) ? 8'(8'h01 << (i - 9)) : 8'h00;
         @(posedge aclk);
         src[i] <= 1'b1;
         @(posedge aclk);
         src[i] <= 1'b0;
         wait_n(2);
         rd_chk(OFS_REQ_A, ea);
         rd_chk(OFS_REQ_B, eb);
         wr(OFS_REQ_A, 8'h7f);
         wr(OFS_REQ_B, 8'h7f);
      end
   endtask : t_events

   task automatic t_pin();
      wr(OFS_EN_A, 8'h01);
      wr(OFS_EN_B, 8'hc0);
      wr(OFS_REQ_A, 8'h82);
      pin(2'b10);
      wr(OFS_REQ_A, 8'h81);
      rd_chk(OFS_REQ_B, 8'h40);
      pin(2'b11);
      wr(OFS_EN_A, 8'h81);
      pin(2'b10);
      wr(OFS_EN_B, 8'h40);
      pin(2'b10);
      wr(OFS_EN_A, 8'h01);
      wait_n(3);
      chk(32'(irq_oe), 32'h0000_0000);
      wr(OFS_EN_B, 8'h80);
      pin(2'b10);
      wr(OFS_EN_B, 8'hc0);
      wr(OFS_REQ_A, 8'h01);
      pin(2'b10);
      rd_chk(OFS_REQ_B, 8'h00);
   endtask : t_pin

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      aresetn = 1'b0;
      src = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      wait_n(2);
      t_reset();
      t_data();
      t_small();
      t_setclr();
      t_events();
      t_pin();
      wrap_up();
   end

   initial begin
      #60000;
      error_cnt++;
      wrap_up();
   end
endmodule : tb
